// *** design/video_port_params.svh ***
`ifndef VIDEO_PORT_PARAMS_SVH
`define VIDEO_PORT_PARAMS_SVH

// register indices on the index/data port
`define VP_IDX_CONTROL 8'h50
`define VP_IDX_FORMAT 8'h51

// reset values
`define VP_CONTROL_RESET 8'h00
`define VP_FORMAT_RESET 8'h00

// control register fields
`define VP_CTL_WMASK 8'h7F
`define VP_CTL_NONINTERLACED 6
`define VP_CTL_FALL_EDGE 5
`define VP_CTL_WIDE_BUS 4
`define VP_CTL_DDC_PINS 3
`define VP_CTL_PINCFG_HI 2
`define VP_CTL_PINCFG_LO 0

// format register fields
`define VP_FMT_BURST_HI 7
`define VP_FMT_BURST_LO 5
`define VP_FMT_DOWNSCALE 4
`define VP_FMT_OP_ENABLE 3
`define VP_FMT_SEL_HI 2
`define VP_FMT_SEL_LO 0

// field codes
`define VP_PINCFG_DISABLED 3'h0
`define VP_PINCFG_ENABLED 3'h1
`define VP_FORMAT_YUV422 3'h0
`define VP_FORMAT_RGB555 3'h1
`define VP_FORMAT_PACKED8 3'h2
`define VP_FORMAT_YUV_PACKED 3'h3

`endif

// *** design/video_port_pkg.sv ***
package video_port_pkg;

  // role of the shared clock-type pin
  typedef enum logic [1:0] {CLK_ROLE_DOT, CLK_ROLE_PIXEL, CLK_ROLE_DDC} clk_role_t;

  // role of the shared data-type pin
  typedef enum logic [1:0] {DAT_ROLE_ACTIVITY, DAT_ROLE_VIDEO_EN, DAT_ROLE_STANDBY,
                            DAT_ROLE_DDC} dat_role_t;

  // port run state, changes only at the vertical sync fall
  typedef enum logic [1:0] {PS_OFF, PS_RUN} port_state_t;

endpackage

// *** design/vport_link_if.sv ***
`timescale 1ns/10ps
interface vport_link_if;
  // levels from the register side
  logic run_lvl;
  logic fall_sel;
  logic wide_sel;
  // captured word and toggle handshake
  logic [15:0] word;
  logic req_tgl;
  logic ack_tgl;

  modport ctrl (output run_lvl, output fall_sel, output wide_sel, output ack_tgl,
                input word, input req_tgl);
  modport link (input run_lvl, input fall_sel, input wide_sel, input ack_tgl,
                output word, output req_tgl);
endinterface

// *** design/vport_link_capture.sv ***
`timescale 1ns/10ps
module vport_link_capture (
  // link clock and reset
  input wire logic port_pixel_clock_in,
  input wire logic rst_n,
  // pixel data pins
  input wire logic [15:0] port_data_in,
  // crossing to the register side
  vport_link_if.link lnk
);
  import video_port_pkg::*;

  logic [1:0] lrst_q;
  logic [3:0] lvl_in;
  logic [3:0] filt_q;
  logic run_f, fall_f, wide_f, ack_f;
  logic [15:0] fall_data_q;
  logic [15:0] sample;
  logic [7:0] low_byte_q;
  logic half_q;
  logic have_q;
  logic [15:0] pend_q;
  logic [15:0] word_q;
  logic req_q;

  // reset release in the link domain
  always_ff @(posedge port_pixel_clock_in or negedge rst_n)
    if (!rst_n)
      lrst_q <= 2'h0;
    else
      lrst_q <= {lrst_q[0], 1'b1};

  // levels arriving from the register side
  assign lvl_in = {lnk.ack_tgl, lnk.wide_sel, lnk.fall_sel, lnk.run_lvl};

  // three-stage synchronisers, a value is taken when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      logic s1_q, s2_q, s3_q, f_q;
      always_ff @(posedge port_pixel_clock_in or negedge lrst_q[1])
        if (!lrst_q[1])
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          f_q <= 1'b0;
        end
        else
        begin
          s1_q <= lvl_in[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q)
            f_q <= s3_q;
        end
      assign filt_q[gi] = f_q;
    end
  endgenerate

  assign run_f = filt_q[0];
  assign fall_f = filt_q[1];
  assign wide_f = filt_q[2];
  assign ack_f = filt_q[3];

  // falling-edge capture register
  always_ff @(negedge port_pixel_clock_in or negedge lrst_q[1])
    if (!lrst_q[1])
      fall_data_q <= 16'h0000;
    else
      fall_data_q <= port_data_in;

  // pick the edge on which data is latched
  assign sample = fall_f ? fall_data_q : port_data_in; // R3

  // byte pairing in narrow mode, low byte first
  always_ff @(posedge port_pixel_clock_in or negedge lrst_q[1])
    if (!lrst_q[1])
    begin
      half_q <= 1'b0;
      low_byte_q <= 8'h00;
      have_q <= 1'b0;
      pend_q <= 16'h0000;
    end
    else
    begin
      have_q <= 1'b0;
      if (!run_f)
        half_q <= 1'b0;
      else if (wide_f) // R4
      begin
        pend_q <= sample;
        have_q <= 1'b1;
      end
      else if (!half_q)
      begin
        low_byte_q <= sample[7:0];
        half_q <= 1'b1;
      end
      else
      begin
        pend_q <= {sample[7:0], low_byte_q};
        have_q <= 1'b1;
        half_q <= 1'b0;
      end
    end

  // hand a word over when the previous one is acknowledged, else drop it
  always_ff @(posedge port_pixel_clock_in or negedge lrst_q[1])
    if (!lrst_q[1])
    begin
      word_q <= 16'h0000;
      req_q <= 1'b0;
    end
    else if (have_q && (req_q == ack_f))
    begin
      word_q <= pend_q;
      req_q <= ~req_q;
    end

  assign lnk.word = word_q;
  assign lnk.req_tgl = req_q;
endmodule

// *** design/video_port_control_format.sv ***
// Functional notes
// R1 - port configuration applies only while the host bus strap reads low; data_format, ddc_pins and the pin roles here ignore the strap
// R2 - control bit 6 clear means interlaced input, set means non-interlaced
// R3 - control bit 5 picks rising or falling pixel clock edge for data
// R4 - bit 4 gives 16-bit bus on PCI hosts; software keeps it clear otherwise
// R5 - control bit 3 or override bit turns shared pins into display channel
// R6 - pin field 000 disables port, 001 enables, other codes reserved
// R7 - display channel pin roles ignore the three-bit pin field
// R8 - writing the pin field alone never starts the port
// R9 - format bits 7:5 set column cycles per fifo fill burst, not flushes
// R10 - format bit 4 enables downscaler for YUV, internal packed and RGB
// R11 - externally packed video is never downscaled; source must do it
// R12 - operation enable clear keeps port off; set runs memory cycles and display
// R13 - software sets the pin field before the operation enable bit
// R14 - operation enable changes only at the falling vertical sync edge
// R15 - format bits 2:0 pick YUV, RGB, packed, YUV packed internally; rest reserved
// R16 - software avoids reserved codes in pin and format fields
`timescale 1ns/10ps
`include "video_port_params.svh"
module video_port_control_format (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // indexed register port
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // straps and extension selects
  input wire logic host_bus_type_strap,
  input wire logic host_is_pci,
  input wire logic ddc_pin_override_bit,
  input wire logic pin_function_select_a4,
  input wire logic pin_function_select_a6,
  input wire logic pin_function_select_b4,
  // video link pins
  input wire logic port_pixel_clock_in,
  input wire logic port_vsync_in,
  input wire logic [15:0] port_data_in,
  // configuration outputs
  output logic port_active,
  output logic non_interlaced,
  output logic sample_falling,
  output logic bus_16bit,
  output logic ddc_pins,
  output video_port_pkg::clk_role_t clk_pin_role,
  output video_port_pkg::dat_role_t dat_pin_role,
  output logic [2:0] fifo_burst_len,
  output logic downscale_en,
  output logic [2:0] data_format,
  // captured pixel stream
  output logic [15:0] pixel_word,
  output logic pixel_valid
);
  import video_port_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_i_n;
  logic [7:0] ctl_q;
  logic [7:0] fmt_q;
  logic [7:0] rdata_q;
  logic [2:0] strap_s_q;
  logic strap_low_q;
  logic strap_taken_q;
  logic [1:0] strap_fill_q;
  logic [2:0] vs_s_q;
  logic vs_filt_q;
  logic vs_fall;
  port_state_t state_q;
  logic cfg_ok;
  logic run;
  logic [2:0] req_s_q;
  logic req_filt_q;
  logic ack_q;
  logic port_active_q, non_interlaced_q, sample_falling_q, bus_16bit_q, ddc_pins_q;
  clk_role_t clk_role_q;
  dat_role_t dat_role_q;
  clk_role_t clk_role_d;
  dat_role_t dat_role_d;
  logic [2:0] burst_q;
  logic downscale_q;
  logic [2:0] format_q;
  logic [15:0] pixel_word_q;
  logic pixel_valid_q;
  logic ddc_sel;
  logic scalable;

  vport_link_if lnk ();

  // field layout must fit the 8-bit registers and the 3-bit codes
  if (`VP_CTL_NONINTERLACED > 7 || `VP_FMT_BURST_HI > 7 ||
      `VP_FMT_BURST_HI - `VP_FMT_BURST_LO != 2 ||
      `VP_CTL_PINCFG_HI - `VP_CTL_PINCFG_LO != 2 ||
      `VP_FMT_SEL_HI - `VP_FMT_SEL_LO != 2)
  begin : g_layout_bad
    $error("register field layout does not fit the port logic");
  end

  // the two registers need indices of their own
  if (`VP_IDX_CONTROL == `VP_IDX_FORMAT)
  begin : g_index_bad
    $error("control and format registers share one index");
  end

  // reset released through two flip-flops
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};

  assign rst_i_n = rst_sync_q[1];

  // control register, reserved bit 7 stays zero
  always_ff @(posedge clock or negedge rst_i_n)
    if (!rst_i_n)
      ctl_q <= `VP_CONTROL_RESET;
    else if (reg_wr && reg_index == `VP_IDX_CONTROL)
      ctl_q <= reg_wdata & `VP_CTL_WMASK;

  // format register
  always_ff @(posedge clock or negedge rst_i_n)
    if (!rst_i_n)
      fmt_q <= `VP_FORMAT_RESET;
    else if (reg_wr && reg_index == `VP_IDX_FORMAT)
      fmt_q <= reg_wdata;

  // read data, unmapped indices read zero
  always_ff @(posedge clock or negedge rst_i_n)
    if (!rst_i_n)
      rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_index)
        `VP_IDX_CONTROL: rdata_q <= ctl_q;
        `VP_IDX_FORMAT: rdata_q <= fmt_q;
        default: rdata_q <= 8'h00;
      endcase
    end

  // strap pin synchroniser
  always_ff @(posedge clock or negedge rst_i_n)
    if (!rst_i_n)
      strap_s_q <= 3'h7;
    else
      strap_s_q <= {strap_s_q[1:0], host_bus_type_strap};

  // strap caught once after reset release, after the pin has filled all three stages;
  // the stages start at their reset value, which must never be taken for the pin
  always_ff @(posedge clock or negedge rst_i_n)
    if (!rst_i_n)
    begin
      strap_fill_q <= 2'h0;
      strap_low_q <= 1'b0;
      strap_taken_q <= 1'b0;
    end
    else if (strap_fill_q != 2'h3)
      strap_fill_q <= strap_fill_q + 2'h1;
    else if (!strap_taken_q && strap_s_q[1] == strap_s_q[2]) // R1
    begin
      strap_low_q <= ~strap_s_q[2];
      strap_taken_q <= 1'b1;
    end

  // vertical sync synchroniser with agreement filter
  always_ff @(posedge clock or negedge rst_i_n)
    if (!rst_i_n)
    begin
      vs_s_q <= 3'h0;
      vs_filt_q <= 1'b0;
    end
    else
    begin
      vs_s_q <= {vs_s_q[1:0], port_vsync_in};
      if (vs_s_q[1] == vs_s_q[2])
        vs_filt_q <= vs_s_q[2];
    end

  assign vs_fall = vs_filt_q && (vs_s_q[1] == vs_s_q[2]) && !vs_s_q[2];

  // pin field must hold the enabled code; reserved codes keep it off
  assign cfg_ok = (ctl_q[`VP_CTL_PINCFG_HI:`VP_CTL_PINCFG_LO] == `VP_PINCFG_ENABLED); // R6

  // operation enable sampled only at the sync fall, never at the write
  always_ff @(posedge clock or negedge rst_i_n)
    if (!rst_i_n)
      state_q <= PS_OFF;
    else if (vs_fall) // R14
    begin
      case (state_q)
        PS_OFF: state_q <= fmt_q[`VP_FMT_OP_ENABLE] ? PS_RUN : PS_OFF; // R8
        PS_RUN: state_q <= fmt_q[`VP_FMT_OP_ENABLE] ? PS_RUN : PS_OFF; // R12
        default: state_q <= PS_OFF;
      endcase
    end

  // port runs with strap low, enable applied and pins configured
  assign run = strap_low_q && (state_q == PS_RUN) && cfg_ok; // R1 R12

  // display channel selection independent of the pin field
  assign ddc_sel = ctl_q[`VP_CTL_DDC_PINS] | ddc_pin_override_bit; // R5 R7

  // externally packed data never goes through the downscaler
  assign scalable = (fmt_q[`VP_FMT_SEL_HI:`VP_FMT_SEL_LO] == `VP_FORMAT_YUV422) ||
                    (fmt_q[`VP_FMT_SEL_HI:`VP_FMT_SEL_LO] == `VP_FORMAT_RGB555) ||
                    (fmt_q[`VP_FMT_SEL_HI:`VP_FMT_SEL_LO] == `VP_FORMAT_YUV_PACKED); // R11

  // registered configuration outputs, gated by the strap
  always_ff @(posedge clock or negedge rst_i_n)
    if (!rst_i_n)
    begin
      port_active_q <= 1'b0;
      non_interlaced_q <= 1'b0;
      sample_falling_q <= 1'b0;
      bus_16bit_q <= 1'b0;
    end
    else
    begin
      port_active_q <= run;
      non_interlaced_q <= strap_low_q & ctl_q[`VP_CTL_NONINTERLACED]; // R2
      sample_falling_q <= strap_low_q & ctl_q[`VP_CTL_FALL_EDGE]; // R3
      bus_16bit_q <= strap_low_q & ctl_q[`VP_CTL_WIDE_BUS] & host_is_pci; // R4
    end

  // next roles of the shared pins, display channel first
  always_comb
  begin
    clk_role_d = CLK_ROLE_PIXEL;
    dat_role_d = DAT_ROLE_ACTIVITY;
    if (ddc_sel) // R5
    begin
      clk_role_d = CLK_ROLE_DDC;
      dat_role_d = DAT_ROLE_DDC;
    end
    else
    begin
      if (pin_function_select_a4 && !pin_function_select_b4)
        clk_role_d = CLK_ROLE_DOT;
      if (pin_function_select_a6)
        dat_role_d = DAT_ROLE_VIDEO_EN;
      else if (pin_function_select_b4)
        dat_role_d = DAT_ROLE_STANDBY;
    end
  end

  // shared pin roles
  always_ff @(posedge clock or negedge rst_i_n)
    if (!rst_i_n)
    begin
      ddc_pins_q <= 1'b0;
      clk_role_q <= CLK_ROLE_PIXEL;
      dat_role_q <= DAT_ROLE_ACTIVITY;
    end
    else
    begin
      ddc_pins_q <= ddc_sel;
      clk_role_q <= clk_role_d;
      dat_role_q <= dat_role_d;
    end

  // burst length, downscaler and format outputs
  always_ff @(posedge clock or negedge rst_i_n)
    if (!rst_i_n)
    begin
      burst_q <= 3'h0;
      downscale_q <= 1'b0;
      format_q <= `VP_FORMAT_YUV422;
    end
    else
    begin
      burst_q <= strap_low_q ? fmt_q[`VP_FMT_BURST_HI:`VP_FMT_BURST_LO] : 3'h0; // R9
      downscale_q <= strap_low_q & fmt_q[`VP_FMT_DOWNSCALE] & scalable; // R10
      format_q <= fmt_q[`VP_FMT_SEL_HI:`VP_FMT_SEL_LO]; // R15
    end

  // levels sent to the link domain
  assign lnk.run_lvl = port_active_q;
  assign lnk.fall_sel = sample_falling_q;
  assign lnk.wide_sel = bus_16bit_q;
  assign lnk.ack_tgl = ack_q;

  // request toggle from the link domain, three stages with agreement
  always_ff @(posedge clock or negedge rst_i_n)
    if (!rst_i_n)
    begin
      req_s_q <= 3'h0;
      req_filt_q <= 1'b0;
    end
    else
    begin
      req_s_q <= {req_s_q[1:0], lnk.req_tgl};
      if (req_s_q[1] == req_s_q[2])
        req_filt_q <= req_s_q[2];
    end

  // accept a word, acknowledge it and present it for memory cycles
  always_ff @(posedge clock or negedge rst_i_n)
    if (!rst_i_n)
    begin
      ack_q <= 1'b0;
      pixel_word_q <= 16'h0000;
      pixel_valid_q <= 1'b0;
    end
    else
    begin
      pixel_valid_q <= 1'b0;
      if (req_filt_q != ack_q)
      begin
        ack_q <= ~ack_q;
        pixel_word_q <= lnk.word;
        pixel_valid_q <= port_active_q; // R12
      end
    end

  // link-side capture
  vport_link_capture u_capture (
    .port_pixel_clock_in(port_pixel_clock_in),
    .rst_n(rst_n),
    .port_data_in(port_data_in),
    .lnk(lnk.link)
  );

  // outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign port_active = port_active_q;
  assign non_interlaced = non_interlaced_q;
  assign sample_falling = sample_falling_q;
  assign bus_16bit = bus_16bit_q;
  assign ddc_pins = ddc_pins_q;
  assign clk_pin_role = clk_role_q;
  assign dat_pin_role = dat_role_q;
  assign fifo_burst_len = burst_q;
  assign downscale_en = downscale_q;
  assign data_format = format_q;
  assign pixel_word = pixel_word_q;
  assign pixel_valid = pixel_valid_q;
endmodule

// *** testbench/vport_cfg_chk.sv ***
`timescale 1ns/10ps
module vport_cfg_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // straps and pins
  input wire logic host_bus_type_strap,
  input wire logic host_is_pci,
  input wire logic ddc_pin_override_bit,
  input wire logic port_vsync_in,
  // configuration outputs
  input wire logic port_active,
  input wire logic non_interlaced,
  input wire logic sample_falling,
  input wire logic bus_16bit,
  input wire logic ddc_pins,
  input video_port_pkg::clk_role_t clk_pin_role,
  input video_port_pkg::dat_role_t dat_pin_role,
  input wire logic [2:0] fifo_burst_len,
  input wire logic downscale_en,
  input wire logic [2:0] data_format,
  input wire logic pixel_valid
);
  import video_port_pkg::*;
  logic [2:0] up_q;
  logic ok;
  // edges since reset, so the release flops and strap capture settle first
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  end
  assign ok = (up_q == 3'h7);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  AST_STRAP_OFF: assert property (ok && host_bus_type_strap |->
    !port_active && !non_interlaced && !sample_falling && !bus_16bit && !downscale_en
    && fifo_burst_len == 3'h0) else $error("mode output set with strap high");
  AST_CTL_MODES: assert property (
    ok && reg_wr && reg_index == 8'h50 && !host_bus_type_strap |-> ##3
    {6'h00, non_interlaced, sample_falling} == (($past(reg_wdata, 3) >> 5) & 8'h03))
    else $error("scan or edge mode differs from control write");
  AST_WIDE_PCI: assert property (bus_16bit |-> $past(host_is_pci))
    else $error("wide bus without pci host");
  AST_DDC_ROLES: assert property (ddc_pins |->
    clk_pin_role == CLK_ROLE_DDC && dat_pin_role == DAT_ROLE_DDC)
    else $error("display channel roles missing");
  AST_OVERRIDE: assert property (ok && ddc_pin_override_bit [*3] |-> ddc_pins)
    else $error("override did not select display channel pins");
  AST_FMT_FIELDS: assert property (
    ok && reg_wr && reg_index == 8'h51 && !host_bus_type_strap |-> ##3
    {5'h00, fifo_burst_len} == ($past(reg_wdata, 3) >> 5)
    && {5'h00, data_format} == ($past(reg_wdata, 3) & 8'h07))
    else $error("burst or format differs from format write");
  AST_DOWNSCALE: assert property (
    downscale_en |-> data_format inside {3'h0, 3'h1, 3'h3})
    else $error("downscaler on for unsupported format");
  AST_ENABLE_VSYNC: assert property (
    ok && $rose(port_active) |-> $past(port_vsync_in, 9) && !$past(port_vsync_in, 2))
    else $error("port started without a sync fall");
  AST_VALID_PULSE: assert property (
    ok && pixel_valid |-> !host_bus_type_strap ##1 !pixel_valid [*3])
    else $error("pixel valid too long or with strap high");
  // main scenarios reached
  cover property (ok && $rose(port_active));
  cover property (pixel_valid && bus_16bit);
  cover property (ok && ddc_pins);
endmodule
bind video_port_control_format vport_cfg_chk u_chk (.clock, .rst_n, .reg_index, .reg_wdata,
  .reg_wr, .host_bus_type_strap, .host_is_pci, .ddc_pin_override_bit, .port_vsync_in,
  .port_active, .non_interlaced, .sample_falling, .bus_16bit, .ddc_pins, .clk_pin_role,
  .dat_pin_role, .fifo_burst_len, .downscale_en, .data_format, .pixel_valid);

// *** testbench/vport_source_model.sv ***
`timescale 1ns/10ps
module vport_source_model (
  // frame request
  input wire logic go,
  // link pins
  output logic port_pixel_clock_in,
  output logic port_vsync_in,
  output logic [15:0] port_data_in
);
  logic [6:0] k;
  // one frame per request; clock stands still between frames
  initial
  begin
    port_pixel_clock_in = 1'b0;
    port_vsync_in = 1'b1;
    port_data_in = 16'h0000;
    k = 7'h00;
    #3.3;
    forever
    begin
      wait (go);
      port_vsync_in = 1'b0;
      // frames arrive full size, any scaling is done here beforehand
      repeat (48)
      begin
        #32 port_pixel_clock_in = 1'b1;
        #16 port_data_in = {~{k, 1'b0}, k, 1'b0}; // even byte seen by falling edge
        #16 port_pixel_clock_in = 1'b0;
        #16 port_data_in = {~{k, 1'b1}, k, 1'b1}; // odd byte seen by rising edge
        k = k + 7'h01;
        #16;
      end
      port_vsync_in = 1'b1;
      port_data_in = ~port_data_in;
      #400;
    end
  end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import video_port_pkg::*;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd; logic [10:0] o;} row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_index = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic host_bus_type_strap = 1'b0;
  logic host_is_pci = 1'b1;
  logic ddc_pin_override_bit = 1'b0;
  logic [2:0] sel = 3'h0;
  logic go = 1'b0;
  logic fall_e = 1'b0;
  logic wide_e = 1'b0;
  logic [7:0] v, reg_rdata;
  logic port_pixel_clock_in, port_vsync_in, port_active, non_interlaced, sample_falling;
  logic bus_16bit, ddc_pins, downscale_en, pixel_valid;
  logic [15:0] port_data_in, pixel_word;
  logic [2:0] fifo_burst_len, data_format;
  logic [10:0] outs;
  clk_role_t clk_pin_role;
  dat_role_t dat_pin_role;
  int fail_count = 0;
  int check_count = 0;
  int nwords = 0;
  int cycles = 0;
  row_t rows [11] = '{{8'h50, 8'hFF, 8'h7F, 11'h780}, {8'h50, 8'h40, 8'h40, 11'h400},
    {8'h51, 8'hB4, 8'hB4, 11'h454}, {8'h51, 8'h10, 8'h10, 11'h408},
    {8'h51, 8'h11, 8'h11, 11'h409}, {8'h51, 8'h12, 8'h12, 11'h402},
    {8'h51, 8'hF3, 8'hF3, 11'h47B}, {8'h50, 8'h30, 8'h30, 11'h37B},
    {8'h51, 8'h15, 8'h15, 11'h305}, {8'h51, 8'h0B, 8'h0B, 11'h303},
    {8'h52, 8'hAA, 8'h00, 11'h303}};
  assign outs = {non_interlaced, sample_falling, bus_16bit, ddc_pins, fifo_burst_len,
    downscale_en, data_format};
  video_port_control_format u_dut (.clock, .rst_n, .reg_index, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .host_bus_type_strap, .host_is_pci, .ddc_pin_override_bit,
    .pin_function_select_a4(sel[2]), .pin_function_select_a6(sel[1]),
    .pin_function_select_b4(sel[0]), .port_pixel_clock_in, .port_vsync_in, .port_data_in,
    .port_active, .non_interlaced, .sample_falling, .bus_16bit, .ddc_pins, .clk_pin_role,
    .dat_pin_role, .fifo_burst_len, .downscale_en, .data_format, .pixel_word, .pixel_valid);
  vport_source_model u_src (.go, .port_pixel_clock_in, .port_vsync_in, .port_data_in);
  always #4 clock = ~clock;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(negedge clock);
    reg_index = idx;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    repeat (4) @(negedge clock);
  endtask
  task automatic rd(input logic [7:0] idx);
    @(negedge clock);
    reg_index = idx;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask
  task automatic reset_dut(input logic s);
    rst_n = 1'b0;
    host_bus_type_strap = s;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    repeat (8) @(negedge clock);
  endtask
  task automatic frame;
    go = 1'b1;
    wait (port_vsync_in === 1'b0);
    go = 1'b0;
    wait (port_vsync_in === 1'b1);
    repeat (20) @(negedge clock);
  endtask
  // each captured word: low byte first in narrow mode, data from the chosen edge
  always @(negedge clock)
  begin
    if (pixel_valid === 1'b1)
    begin
      nwords++;
      check({8'h00, pixel_word[15:8]},
        {8'h00, wide_e ? ~pixel_word[7:0] : pixel_word[7:0] + 8'h02});
      check({15'h0000, pixel_word[0]}, {15'h0000, !fall_e});
    end
  end
  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      conclude();
    end
  end
  // main sequence
  initial
  begin
    reset_dut(1'b0);
    rd(8'h50);
    check({8'h00, v}, 16'h0000);
    rd(8'h51);
    check({8'h00, v}, 16'h0000);
    check({clk_pin_role, dat_pin_role, port_active, outs}, 16'h4000);
    foreach (rows[i])
    begin
      wr(rows[i].idx, rows[i].wd);
      rd(rows[i].idx);
      check({8'h00, v}, {8'h00, rows[i].rd});
      check({4'h0, port_active, outs}, {5'h00, rows[i].o});
    end
    for (int j = 0; j < 8; j++)
    begin
      sel = 3'(j);
      repeat (3) @(negedge clock);
      check({12'h000, clk_pin_role, dat_pin_role}, {12'h000,
        ((sel[2] && !sel[0]) ? CLK_ROLE_DOT : CLK_ROLE_PIXEL),
        (sel[1] ? DAT_ROLE_VIDEO_EN : (sel[0] ? DAT_ROLE_STANDBY : DAT_ROLE_ACTIVITY))});
    end
    ddc_pin_override_bit = 1'b1;
    repeat (3) @(negedge clock);
    check({12'h000, clk_pin_role, dat_pin_role}, {12'h000, CLK_ROLE_DDC, DAT_ROLE_DDC});
    ddc_pin_override_bit = 1'b0;
    wr(8'h50, 8'h01);
    wr(8'h51, 8'h08);
    repeat (40) @(negedge clock);
    check({15'h0000, port_active}, 16'h0000);
    frame();
    check({15'h0000, port_active}, 16'h0001);
    check({15'h0000, nwords != 0}, 16'h0001);
    wr(8'h51, 8'h00);
    repeat (40) @(negedge clock);
    check({15'h0000, port_active}, 16'h0001);
    frame();
    check({15'h0000, port_active}, 16'h0000);
    wr(8'h50, 8'h31);
    wr(8'h51, 8'h08);
    fall_e = 1'b1;
    wide_e = 1'b1;
    nwords = 0;
    frame();
    check({15'h0000, port_active}, 16'h0001);
    check({15'h0000, nwords != 0}, 16'h0001);
    wr(8'h50, 8'h02);
    check({15'h0000, port_active}, 16'h0000);
    host_is_pci = 1'b0;
    wr(8'h50, 8'h10);
    check({15'h0000, bus_16bit}, 16'h0000);
    reset_dut(1'b1);
    wr(8'h50, 8'h71);
    wr(8'h51, 8'hFF);
    frame();
    check({4'h0, port_active, outs}, 16'h0007);
    conclude();
  end
endmodule
